// ==== inc/base_clock_pkg.sv ====
// Constants, register map and types of the base clock generator.
// Assumes one control clock that never stops and a plain register port.
// Operation
// - Control logic runs on never-stopping control clock.
// - Base clocks 0..11; index 10 reserved.
// - Safe and control clocks use only ring oscillator.
// - Dividers take PLL or primary oscillators only.
// - PLL fed by crystal; three phase outputs.
// - Illegal source write keeps old source field.
// - Everything selects ring oscillator after reset.
// - Selecting inactive source is masked, not stored.
// - Source inactive after 32 edgeless control cycles.
// - After reset all sources reported absent.
// - Detectors flag activation and deactivation events.
// - Dead selected clock still raises deactivation event.
// - Source switching is glitch-free at both stages.
// - PLL switch holds output low until lock.
// - Other switches finish fast with short low.
// - Old clock stuck high 32 cycles forced low.
// - PLL divides by twice P or passes directly.
// - Ring oscillator refuses power-down requests.
// - Post divider gives 2, 4, 8 or 16.
// - Lock stays low while PLL powered down.
package base_clock_pkg;

  // ----------------------------------------------------------------
  // Sizes and source numbering
  // ----------------------------------------------------------------
  localparam int NUM_SOURCES = 12;
  localparam int NUM_BASE = 12;
  localparam int NUM_FRACTIONAL_DIVIDER = 7;
  localparam int NUM_PLL = 3;
  localparam logic [3:0] SRC_RING = 4'h0;
  localparam logic [3:0] SRC_XTAL = 4'h1;
  localparam logic [3:0] SRC_PLL_FIRST = 4'h2;
  localparam logic [3:0] SRC_PLL_LAST = 4'h4;
  localparam logic [3:0] SRC_LAST = 4'hB;
  localparam int BASE_SAFE = 0;
  localparam int BASE_SYS = 1;
  localparam int BASE_CTRL = 2;
  localparam int BASE_RESERVED = 10;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] BASE_SEL_OFS = 8'h00;
  localparam logic [7:0] FRACTIONAL_DIVIDER_CTL_OFS = 8'h30;
  localparam logic [7:0] PLL_CTL_OFS = 8'h4C;
  localparam logic [7:0] OSC_CTL_OFS = 8'h50;
  localparam logic [7:0] ACT_STATUS_OFS = 8'h54;
  localparam logic [7:0] PLL_STATUS_OFS = 8'h58;
  localparam int SEL_LSB = 0;
  localparam int FRACTIONAL_DIVIDER_L_LSB = 4;
  localparam int FRACTIONAL_DIVIDER_D_LSB = 12;
  localparam int PLL_PD_BIT = 0;
  localparam int PLL_DIRECT_BIT = 1;
  localparam int PLL_PSEL_LSB = 2;
  localparam int OSC_XTAL_PD_BIT = 0;
  localparam int OSC_RING_PD_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values and timing counts in control clock cycles
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [7:0] FRACTIONAL_DIVIDER_L_RESET = 8'h01;
  localparam logic [7:0] FRACTIONAL_DIVIDER_D_RESET = 8'h01;
  localparam logic PLL_PD_RESET = 1'b1;
  localparam logic [1:0] PLL_PSEL_RESET = 2'h0;
  localparam logic XTAL_PD_RESET = 1'b0;
  localparam int ACT_WINDOW_CYCLES = 32;
  localparam int STUCK_WINDOW_CYCLES = 32;
  localparam int HOLD_CYCLES = 2;

  typedef enum logic [1:0] {GEN_RUN, GEN_DRAIN, GEN_HOLD} gen_state_e;

endpackage : base_clock_pkg

// ==== src/base_clock_generator.sv ====
// Base clock generator: source selection, dividers, PLL post divider,
// activity detection and glitch-free switching of twelve base clocks.
// Assumes clock sources arrive as levels sampled by the control clock.
`timescale 1ns/1ps
module base_clock_generator #(
  parameter int ACT_WINDOW = base_clock_pkg::ACT_WINDOW_CYCLES,
  parameter int STUCK_WINDOW = base_clock_pkg::STUCK_WINDOW_CYCLES
) (
  // Control clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Clock sources
  input wire logic ring_osc_i,
  input wire logic xtal_osc_i,
  input wire logic [2:0] pll_cco_i,
  input wire logic pll_lock_detect_i,
  // Generated clocks and analogue controls
  output logic [11:0] base_clock_o,
  output logic xtal_power_down_o,
  output logic pll_power_down_o,
  output logic pll_lock_o,
  // Activity events
  output logic [11:0] activity_rise_o,
  output logic [11:0] activity_fall_o
);

  initial begin
    if (ACT_WINDOW < 2 || ACT_WINDOW > 63 || STUCK_WINDOW < 2 || STUCK_WINDOW > 63) begin
      $error("base_clock_generator: window counts must lie in 2..63");
    end
  end

  localparam logic [5:0] ACT_LAST = 6'(ACT_WINDOW - 1);
  localparam logic [5:0] STUCK_LAST = 6'(STUCK_WINDOW - 1);
  localparam logic [5:0] HOLD_LAST = 6'(base_clock_pkg::HOLD_CYCLES - 1);

  typedef struct packed {
    logic [4:0] raw_meta;
    logic [4:0] raw_sync;
    logic [4:0] raw_prev;
    logic [11:0] src_prev;
    logic [11:0][5:0] act_cnt;
    logic [11:0] active;
    logic [11:0] rise;
    logic [11:0] fall;
    logic [11:0][3:0] cur_sel;
    logic [11:0][3:0] pend_sel;
    base_clock_pkg::gen_state_e [11:0] gen_state;
    logic [11:0][5:0] gen_cnt;
    logic [11:0] base_clk;
    logic [6:0][3:0] fd_sel;
    logic [6:0][7:0] fd_l;
    logic [6:0][7:0] fd_d;
    logic [6:0][7:0] fd_acc;
    logic [6:0] fd_out;
    logic pll_pd;
    logic pll_direct;
    logic [1:0] pll_psel;
    logic [2:0][7:0] pll_cnt;
    logic [2:0] pll_out;
    logic pll_lock;
    logic xtal_pd;
    logic [31:0] rdata;
  } state_s;

  state_s s;
  state_s next_s;
  logic [11:0] src_lvl;
  logic [11:0] src_edge;
  logic [5:0] word;
  logic [7:0] pll_last;

  // ----------------------------------------------------------------
  // Source levels seen by detectors and generators
  // ----------------------------------------------------------------
  assign src_lvl = {s.fd_out, s.pll_out, s.raw_sync[1], s.raw_sync[0]};
  assign src_edge = src_lvl & ~s.src_prev;
  assign word = addr_i[7:2];
  assign pll_last = 8'((9'h001 << s.pll_psel) - 9'h001);

  function automatic logic is_pll(input logic [3:0] sel);
    is_pll = (sel >= base_clock_pkg::SRC_PLL_FIRST) && (sel <= base_clock_pkg::SRC_PLL_LAST);
  endfunction : is_pll

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [8:0] fd_sum;
    logic [3:0] wsel;
    logic [3:0] fsrc;
    fd_sum = 9'h000;
    wsel = wdata_i[base_clock_pkg::SEL_LSB +: 4];
    fsrc = 4'h0;
    next_s = s;
    next_s.raw_meta = {pll_cco_i, xtal_osc_i, ring_osc_i};
    next_s.raw_sync = s.raw_meta;
    next_s.raw_prev = s.raw_sync;
    next_s.src_prev = src_lvl;
    next_s.rdata = 32'h0000_0000;

    // Activity detectors: an edge marks the source alive, a quiet window marks it dead.
    for (int k = 0; k < base_clock_pkg::NUM_SOURCES; k++) begin
      if (src_edge[k]) begin
        next_s.act_cnt[k] = 6'h00;
        next_s.active[k] = 1'b1;
      end else if (s.act_cnt[k] == ACT_LAST) begin
        next_s.active[k] = 1'b0;
      end else begin
        next_s.act_cnt[k] = s.act_cnt[k] + 6'h01;
      end
      // Events fire even for a source that a generator is still passing out.
      next_s.rise[k] = next_s.active[k] & ~s.active[k];
      next_s.fall[k] = ~next_s.active[k] & s.active[k];
    end

    // PLL post divider on the crystal-referenced oscillator phases.
    for (int p = 0; p < base_clock_pkg::NUM_PLL; p++) begin
      if (s.pll_pd) begin
        next_s.pll_cnt[p] = 8'h00;
        next_s.pll_out[p] = 1'b0;
      end else if (s.pll_direct) begin
        next_s.pll_out[p] = s.raw_sync[2 + p];
      end else if (s.raw_sync[2 + p] && !s.raw_prev[2 + p]) begin
        if (s.pll_cnt[p] >= pll_last) begin
          next_s.pll_cnt[p] = 8'h00;
          next_s.pll_out[p] = ~s.pll_out[p];
        end else begin
          next_s.pll_cnt[p] = s.pll_cnt[p] + 8'h01;
        end
      end
    end

    // Fractional dividers: output pulse train of L per D input edges.
    // With L equal to D every edge overflows, so the output sits high and reads inactive.
    for (int f = 0; f < base_clock_pkg::NUM_FRACTIONAL_DIVIDER; f++) begin
      fsrc = s.fd_sel[f];
      fd_sum = {1'b0, s.fd_acc[f]} + {1'b0, s.fd_l[f]};
      // Only edges of the one selected source count, so a new selection adds no stray pulse.
      if (src_edge[fsrc] && (!is_pll(fsrc) || s.pll_lock)) begin
        if (fd_sum >= {1'b0, s.fd_d[f]}) begin
          next_s.fd_acc[f] = 8'(fd_sum - {1'b0, s.fd_d[f]});
          next_s.fd_out[f] = 1'b1;
        end else begin
          next_s.fd_acc[f] = fd_sum[7:0];
          next_s.fd_out[f] = 1'b0;
        end
      end
    end

    // Output generators.
    for (int g = 0; g < base_clock_pkg::NUM_BASE; g++) begin
      case (s.gen_state[g])
        base_clock_pkg::GEN_RUN: begin
          next_s.base_clk[g] = src_lvl[s.cur_sel[g]];
        end
        base_clock_pkg::GEN_DRAIN: begin
          if (!src_lvl[s.cur_sel[g]]) begin
            next_s.base_clk[g] = 1'b0;
            next_s.gen_state[g] = base_clock_pkg::GEN_HOLD;
            next_s.gen_cnt[g] = 6'h00;
          end else if (s.gen_cnt[g] == STUCK_LAST) begin
            next_s.base_clk[g] = 1'b0;
            next_s.gen_state[g] = base_clock_pkg::GEN_HOLD;
            next_s.gen_cnt[g] = 6'h00;
          end else begin
            next_s.base_clk[g] = 1'b1;
            next_s.gen_cnt[g] = s.gen_cnt[g] + 6'h01;
          end
        end
        base_clock_pkg::GEN_HOLD: begin
          next_s.base_clk[g] = 1'b0;
          next_s.cur_sel[g] = s.pend_sel[g];
          if (s.gen_cnt[g] < HOLD_LAST) begin
            next_s.gen_cnt[g] = s.gen_cnt[g] + 6'h01;
          end else if (!src_lvl[s.pend_sel[g]] && (!is_pll(s.pend_sel[g]) || s.pll_lock)) begin
            next_s.gen_state[g] = base_clock_pkg::GEN_RUN;
          end
        end
        default: begin
          next_s.gen_state[g] = base_clock_pkg::GEN_RUN;
        end
      endcase
      if (g == base_clock_pkg::BASE_RESERVED) begin
        next_s.base_clk[g] = 1'b0;
      end
    end

    // Register writes.
    if (wr_i) begin
      if (addr_i < base_clock_pkg::FRACTIONAL_DIVIDER_CTL_OFS) begin
        for (int g = 0; g < base_clock_pkg::NUM_BASE; g++) begin
          if (word == 6'(g) && g != base_clock_pkg::BASE_RESERVED
              && wsel <= base_clock_pkg::SRC_LAST && s.active[wsel]
              && ((g != base_clock_pkg::BASE_SAFE && g != base_clock_pkg::BASE_CTRL)
                  || wsel == base_clock_pkg::SRC_RING)) begin
            next_s.pend_sel[g] = wsel;
            if (s.gen_state[g] == base_clock_pkg::GEN_RUN && wsel != s.cur_sel[g]) begin
              next_s.gen_state[g] = base_clock_pkg::GEN_DRAIN;
              next_s.gen_cnt[g] = 6'h00;
            end
          end
        end
      end else if (addr_i < base_clock_pkg::PLL_CTL_OFS) begin
        for (int f = 0; f < base_clock_pkg::NUM_FRACTIONAL_DIVIDER; f++) begin
          if (word == 6'(f + 12)) begin
            next_s.fd_l[f] = wdata_i[base_clock_pkg::FRACTIONAL_DIVIDER_L_LSB +: 8];
            next_s.fd_d[f] = wdata_i[base_clock_pkg::FRACTIONAL_DIVIDER_D_LSB +: 8];
            if (wsel <= base_clock_pkg::SRC_PLL_LAST && s.active[wsel]) begin
              next_s.fd_sel[f] = wsel;
            end
          end
        end
      end else if (addr_i == base_clock_pkg::PLL_CTL_OFS) begin
        next_s.pll_pd = wdata_i[base_clock_pkg::PLL_PD_BIT];
        next_s.pll_direct = wdata_i[base_clock_pkg::PLL_DIRECT_BIT];
        next_s.pll_psel = wdata_i[base_clock_pkg::PLL_PSEL_LSB +: 2];
      end else if (addr_i == base_clock_pkg::OSC_CTL_OFS) begin
        // The ring oscillator power-down bit is not stored at all.
        next_s.xtal_pd = wdata_i[base_clock_pkg::OSC_XTAL_PD_BIT];
      end
    end

    // Lock follows the detector but never while powered down.
    next_s.pll_lock = pll_lock_detect_i & ~next_s.pll_pd;

    // Register reads.
    if (rd_i) begin
      if (addr_i < base_clock_pkg::FRACTIONAL_DIVIDER_CTL_OFS) begin
        for (int g = 0; g < base_clock_pkg::NUM_BASE; g++) begin
          if (word == 6'(g)) begin
            next_s.rdata = {28'h0000000, s.pend_sel[g]};
          end
        end
      end else if (addr_i < base_clock_pkg::PLL_CTL_OFS) begin
        for (int f = 0; f < base_clock_pkg::NUM_FRACTIONAL_DIVIDER; f++) begin
          if (word == 6'(f + 12)) begin
            next_s.rdata = {12'h000, s.fd_d[f], s.fd_l[f], s.fd_sel[f]};
          end
        end
      end else if (addr_i == base_clock_pkg::PLL_CTL_OFS) begin
        next_s.rdata = {28'h0000000, s.pll_psel, s.pll_direct, s.pll_pd};
      end else if (addr_i == base_clock_pkg::OSC_CTL_OFS) begin
        next_s.rdata = {31'h00000000, s.xtal_pd};
      end else if (addr_i == base_clock_pkg::ACT_STATUS_OFS) begin
        next_s.rdata = {20'h00000, s.active};
      end else if (addr_i == base_clock_pkg::PLL_STATUS_OFS) begin
        next_s.rdata = {31'h00000000, s.pll_lock};
      end
    end
  end

  // ----------------------------------------------------------------
  // State register on the never-stopping control clock
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
      s.fd_l <= {7{base_clock_pkg::FRACTIONAL_DIVIDER_L_RESET}};
      s.fd_d <= {7{base_clock_pkg::FRACTIONAL_DIVIDER_D_RESET}};
      s.pll_pd <= base_clock_pkg::PLL_PD_RESET;
      s.pll_psel <= base_clock_pkg::PLL_PSEL_RESET;
      s.xtal_pd <= base_clock_pkg::XTAL_PD_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
  assign base_clock_o = s.base_clk;
  assign xtal_power_down_o = s.xtal_pd;
  assign pll_power_down_o = s.pll_pd;
  assign pll_lock_o = s.pll_lock;
  assign activity_rise_o = s.rise;
  assign activity_fall_o = s.fall;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  ring_only_sel_a: assert property (@(posedge clock_i) disable iff (rst_i)
    s.cur_sel[0] == 4'h0 && s.pend_sel[0] == 4'h0 && s.cur_sel[2] == 4'h0)
    else $error("safe or control clock left the ring oscillator");

  fractional_divider_src_a: assert property (@(posedge clock_i) disable iff (rst_i)
    s.fd_sel[0] <= base_clock_pkg::SRC_PLL_LAST && s.fd_sel[6] <= base_clock_pkg::SRC_PLL_LAST)
    else $error("divider fed from a divider");

  dead_sel_kept_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_i && word == 6'h01 && wdata_i[3:0] == 4'h1 && !s.active[1] |=> $stable(s.pend_sel[1]))
    else $error("inactive source was stored");

  reset_ring_a: assert property (@(posedge clock_i)
    $fell(rst_i) |-> s.cur_sel == '0 && s.fd_sel == '0)
    else $error("source not ring oscillator after reset");

  reset_absent_a: assert property (@(posedge clock_i)
    $fell(rst_i) |-> s.active == 12'h000 ##1 activity_rise_o == 12'h000 || src_lvl != 12'h000)
    else $error("source reported present straight after reset");

  quiet_dead_a: assert property (@(posedge clock_i) disable iff (rst_i)
    s.active[1] && s.act_cnt[1] == ACT_LAST && !src_edge[1] |=> !s.active[1] && activity_fall_o[1])
    else $error("quiet source not declared inactive");

  rise_event_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(s.active[0]) |-> activity_rise_o[0] ##1 !activity_rise_o[0])
    else $error("activation event missing or too long");

  stuck_force_a: assert property (@(posedge clock_i) disable iff (rst_i)
    s.gen_state[3] == base_clock_pkg::GEN_DRAIN && s.gen_cnt[3] == STUCK_LAST
    |=> !base_clock_o[3] && s.gen_state[3] == base_clock_pkg::GEN_HOLD)
    else $error("stuck clock not forced low");

  pll_wait_a: assert property (@(posedge clock_i) disable iff (rst_i)
    s.gen_state[5] == base_clock_pkg::GEN_HOLD && is_pll(s.pend_sel[5]) && !s.pll_lock
    |=> s.gen_state[5] != base_clock_pkg::GEN_RUN && !base_clock_o[5])
    else $error("PLL clock released before lock");

  lock_pd_a: assert property (@(posedge clock_i) disable iff (rst_i)
    s.pll_pd |-> !pll_lock_o)
    else $error("lock high while PLL powered down");

  post_div_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !s.pll_pd && !s.pll_direct && $stable(s.pll_pd) && $stable(s.pll_direct) && $changed(s.pll_out[0])
    |-> $past(s.pll_cnt[0]) >= $past(pll_last))
    else $error("post divider toggled early");

  ring_pd_a: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_i && addr_i == base_clock_pkg::OSC_CTL_OFS |=> !rdata_o[base_clock_pkg::OSC_RING_PD_BIT])
    else $error("ring oscillator power-down accepted");

  reserved_low_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !base_clock_o[base_clock_pkg::BASE_RESERVED])
    else $error("reserved base clock toggled");

  fall_event_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $fell(s.active[1]) |-> activity_fall_o[1] ##1 !activity_fall_o[1])
    else $error("deactivation event missing or too long");

  div_mask_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_i && addr_i == base_clock_pkg::FRACTIONAL_DIVIDER_CTL_OFS && wdata_i[3:0] == 4'h1 && !s.active[1]
    |=> $stable(s.fd_sel[0]))
    else $error("divider took an inactive source");

  lock_follow_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !s.pll_pd && pll_lock_detect_i && !(wr_i && addr_i == base_clock_pkg::PLL_CTL_OFS)
    |=> pll_lock_o)
    else $error("lock not raised after power-up");

  status_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_i && addr_i == base_clock_pkg::ACT_STATUS_OFS |=> rdata_o[11:0] == $past(s.active))
    else $error("activity status read back wrong");

  drain_pass_a: assert property (@(posedge clock_i) disable iff (rst_i)
    s.gen_state[1] == base_clock_pkg::GEN_DRAIN && src_lvl[s.cur_sel[1]]
    && s.gen_cnt[1] != STUCK_LAST |=> base_clock_o[1])
    else $error("old clock cut short during switch");

  hold_exit_a: assert property (@(posedge clock_i) disable iff (rst_i)
    s.gen_state[1] == base_clock_pkg::GEN_HOLD && s.gen_cnt[1] >= HOLD_LAST
    && !is_pll(s.pend_sel[1]) && !src_lvl[s.pend_sel[1]] |=> s.gen_state[1] == base_clock_pkg::GEN_RUN)
    else $error("switch to a plain source stalled");

  reset_pd_a: assert property (@(posedge clock_i)
    $fell(rst_i) |-> pll_power_down_o && !pll_lock_o)
    else $error("PLL not powered down after reset");

endmodule : base_clock_generator

// ==== verification/tb_base_clock_generator.sv ====
// Self-checking testbench of the base clock generator.
// Assumes the block is the only device: the bench drives the register port and every source.
`timescale 1ns/1ps
module tb_base_clock_generator;
  localparam int WIN = 8;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic ring_osc_i = 1'b0;
  logic xtal_osc_i = 1'b0;
  logic [2:0] pll_cco_i = 3'h0;
  logic pll_lock_detect_i = 1'b1;
  logic [11:0] base_clock_o;
  logic xtal_power_down_o;
  logic pll_power_down_o;
  logic pll_lock_o;
  logic [11:0] activity_rise_o;
  logic [11:0] activity_fall_o;
  logic ring_en = 1'b1;
  logic ring_stuck = 1'b0;
  logic xtal_en = 1'b0;
  logic pll_en = 1'b0;
  logic clr = 1'b0;
  logic [2:0] cnt = 3'h0;
  logic [11:0] rise_seen = 12'h0;
  logic [11:0] fall_seen = 12'h0;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;

  base_clock_generator #(.ACT_WINDOW(WIN), .STUCK_WINDOW(WIN)) dut (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .ring_osc_i(ring_osc_i), .xtal_osc_i(xtal_osc_i),
    .pll_cco_i(pll_cco_i), .pll_lock_detect_i(pll_lock_detect_i),
    .base_clock_o(base_clock_o), .xtal_power_down_o(xtal_power_down_o),
    .pll_power_down_o(pll_power_down_o), .pll_lock_o(pll_lock_o),
    .activity_rise_o(activity_rise_o), .activity_fall_o(activity_fall_o));

  initial begin
    forever #2.5 clock_i = ~clock_i;
  end

  // --------------------------------------------------------------
  // Source clocks, sticky event capture and hang guard
  // --------------------------------------------------------------
  // Sources are slower than the control clock so its sampling sees every edge.
  always @(posedge clock_i) begin
    cnt <= cnt + 3'h1;
    ring_osc_i <= ring_stuck | (ring_en & cnt[1]);
    xtal_osc_i <= xtal_en & cnt[0];
    pll_cco_i <= {3{pll_en}} & {cnt[1], ~cnt[0], cnt[0]};
    rise_seen <= clr ? 12'h0 : (rise_seen | activity_rise_o);
    fall_seen <= clr ? 12'h0 : (fall_seen | activity_fall_o);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask : rd_chk

  task automatic clear_ev();
    @(posedge clock_i);
    clr <= 1'b1;
    @(posedge clock_i);
    clr <= 1'b0;
  endtask : clear_ev

  // Counts cycles until the base clock reaches the given level.
  task automatic wait_level(input int b, input logic lvl, input int lim, output int n);
    n = 0;
    while (base_clock_o[b] !== lvl && n < lim) begin
      @(posedge clock_i);
      #1 n++;
    end
  endtask : wait_level

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    #1 chk({31'h0, pll_power_down_o}, 32'h1);
    chk({31'h0, pll_lock_o}, 32'h0);
    rd_chk(base_clock_pkg::ACT_STATUS_OFS, 32'h0);
    for (int g = 0; g < 12; g++) rd_chk(8'(4 * g), 32'h0);
    for (int f = 0; f < 7; f++) rd_chk(8'(8'h30 + 4 * f), 32'h00001010);
    rd_chk(8'hFC, 32'h0);
    chk({31'h0, rise_seen[0]}, 32'h1);
  endtask : t_reset

  task automatic t_mask_inactive();
    wr(8'h04, 32'h1);
    rd_chk(8'h04, 32'h0);
    wr(8'h30, 32'h00005051);
    rd_chk(8'h30, 32'h00005050);
  endtask : t_mask_inactive

  task automatic t_activity();
    clear_ev();
    xtal_en <= 1'b1;
    repeat (WIN + 8) @(posedge clock_i);
    rd_chk(base_clock_pkg::ACT_STATUS_OFS, 32'h3);
    chk({30'h0, rise_seen[1:0]}, 32'h2);
  endtask : t_activity

  task automatic t_legal();
    wr(8'h00, 32'h1);
    rd_chk(8'h00, 32'h0);
    wr(8'h08, 32'h1);
    rd_chk(8'h08, 32'h0);
    wr(8'h28, 32'h1);
    rd_chk(8'h28, 32'h0);
    wr(8'h10, 32'hC);
    rd_chk(8'h10, 32'h0);
    wr(8'h10, 32'h1);
    rd_chk(8'h10, 32'h1);
    wr(8'h34, 32'h00007025);
    rd_chk(8'h34, 32'h00007020);
    wr(8'h34, 32'h00001011);
    rd_chk(8'h34, 32'h00001011);
  endtask : t_legal

  task automatic t_switch();
    int n;
    wr(8'h04, 32'h1);
    wait_level(1, 1'b0, 10, n);
    wait_level(1, 1'b1, 40, n);
    chk({31'h0, n >= base_clock_pkg::HOLD_CYCLES}, 32'h1);
    chk({31'h0, n < 40}, 32'h1);
    @(posedge clock_i);
    #1 chk({31'h0, base_clock_o[1]}, 32'h0);
  endtask : t_switch

  task automatic t_stuck();
    int n;
    ring_stuck <= 1'b1;
    repeat (6) @(posedge clock_i);
    #1 chk({31'h0, base_clock_o[3]}, 32'h1);
    wr(8'h0C, 32'h1);
    wait_level(3, 1'b0, 40, n);
    chk({31'h0, n > 1 && n <= WIN + 4}, 32'h1);
    ring_stuck <= 1'b0;
    repeat (WIN + 8) @(posedge clock_i);
  endtask : t_stuck

  task automatic t_deactivate();
    clear_ev();
    xtal_en <= 1'b0;
    repeat (WIN - 2) @(posedge clock_i);
    #1 chk({31'h0, fall_seen[1]}, 32'h0);
    repeat (10) @(posedge clock_i);
    #1 chk({31'h0, fall_seen[1]}, 32'h1);
    rd_chk(base_clock_pkg::ACT_STATUS_OFS, 32'h1);
  endtask : t_deactivate

  task automatic t_pll();
    int n;
    int hi;
    pll_en <= 1'b1;
    pll_lock_detect_i <= 1'b0;
    wr(base_clock_pkg::PLL_CTL_OFS, 32'h0);
    repeat (WIN + 8) @(posedge clock_i);
    rd_chk(base_clock_pkg::ACT_STATUS_OFS, 32'h1D);
    wr(8'h14, 32'h2);
    wait_level(5, 1'b0, 10, n);
    hi = 0;
    repeat (30) begin
      @(posedge clock_i);
      #1 hi += int'(base_clock_o[5] !== 1'b0);
    end
    chk(32'(hi), 32'h0);
    pll_lock_detect_i <= 1'b1;
    wait_level(5, 1'b1, 20, n);
    chk({31'h0, n < 20}, 32'h1);
    chk({31'h0, pll_lock_o}, 32'h1);
    rd_chk(base_clock_pkg::PLL_STATUS_OFS, 32'h1);
    wr(8'h38, 32'h00001012);
    rd_chk(8'h38, 32'h00001012);
    wr(base_clock_pkg::PLL_CTL_OFS, 32'h1);
    repeat (2) @(posedge clock_i);
    #1 chk({30'h0, pll_lock_o, pll_power_down_o}, 32'h1);
  endtask : t_pll

  task automatic t_osc();
    wr(base_clock_pkg::OSC_CTL_OFS, 32'h3);
    rd_chk(base_clock_pkg::OSC_CTL_OFS, 32'h1);
    chk({31'h0, xtal_power_down_o}, 32'h1);
    wr(base_clock_pkg::OSC_CTL_OFS, 32'h0);
  endtask : t_osc

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset();
    t_mask_inactive();
    t_activity();
    t_legal();
    t_switch();
    t_stuck();
    t_deactivate();
    t_pll();
    t_osc();
    conclude();
  end
endmodule : tb_base_clock_generator
